// ### rtl/fbsm_defines.vh
// Purpose: constants for the fieldbus slave state machine
// Assumes: 100 MHz mclk, 16-bit register port
// Notes:   included by the design files and the test bench
`ifndef FBSM_DEFINES_VH
`define FBSM_DEFINES_VH

// register offsets
`define FBSM_REG_CTRL        16'h0120
`define FBSM_REG_STATUS      16'h0130

// control word fields
`define FBSM_CTRL_REQ_HI     3
`define FBSM_CTRL_REQ_LO     0
`define FBSM_CTRL_ACK_BIT    4
`define FBSM_CTRL_RESET      16'h0001

// state request codes / state encodings
`define FBSM_ST_INIT         4'h1
`define FBSM_ST_PREOP        4'h2
`define FBSM_ST_BOOT         4'h3
`define FBSM_ST_SAFEOP       4'h4
`define FBSM_ST_OP           4'h8

// mailbox protocol and service codes
`define FBSM_PROTO_COE       4'h3
`define FBSM_PROTO_FOE       4'h4
`define FBSM_SDO_REQ         4'h2
`define FBSM_SDO_RESP        4'h3
`define FBSM_SDO_CA          4'h4

// process data
`define FBSM_DEF_SETPOINT    16'h0000
`define FBSM_FIFO_WIDTH      16
`define FBSM_FIFO_DEPTH      16
`define FBSM_FIFO_AW         4

// link timing: 100 Mbit/s over a 4-bit lane gives one nibble per 40 ns
`define FBSM_CLK_MHZ         100
`define FBSM_LINK_MBPS       100
`define FBSM_LANE_BITS       4
`define FBSM_LINK_DIV        ((`FBSM_CLK_MHZ * `FBSM_LANE_BITS) / `FBSM_LINK_MBPS)
`define FBSM_DIV_W           2

`endif

// ### rtl/fbsm_fifo.v
// Purpose: process data fifo with registered read data
// Assumes: single clock, synchronous active high reset
// Notes:   in_ready comes from a flip-flop
`include "fbsm_defines.vh"

module fbsm_fifo #(
    parameter WIDTH = `FBSM_FIFO_WIDTH,
    parameter DEPTH = `FBSM_FIFO_DEPTH,
    parameter AW    = `FBSM_FIFO_AW
) (
    // clock and reset
    input  wire             mclk,
    input  wire             rst,
    // write side
    input  wire             in_valid,
    input  wire [WIDTH-1:0] in_data,
    output reg              in_ready,
    // read side
    output reg              out_valid,
    output reg  [WIDTH-1:0] out_data,
    input  wire             out_ready
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wptr_q;
    reg [AW-1:0]    rptr_q;
    reg [AW:0]      cnt_q;
    reg [AW:0]      cnt_d;
    wire            push;
    wire            pop;

    assign push = in_valid & in_ready;
    assign pop  = (cnt_q != {(AW+1){1'b0}}) & (~out_valid | out_ready);

    always @* begin
        cnt_d = cnt_q;
        if (push & ~pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop & ~push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always @(posedge mclk) begin
        if (push) begin
            mem[wptr_q] <= in_data;
        end
        if (pop) begin
            out_data <= mem[rptr_q];
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            wptr_q    <= {AW{1'b0}};
            rptr_q    <= {AW{1'b0}};
            cnt_q     <= {(AW+1){1'b0}};
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            cnt_q    <= cnt_d;
            in_ready <= (cnt_d < DEPTH);
            if (push) begin
                wptr_q <= wptr_q + 1'b1;
            end
            if (pop) begin
                rptr_q    <= rptr_q + 1'b1;
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end

endmodule

// ### rtl/fbsm_core.v
// Purpose: slave application-layer state machine of a fieldbus interface
// Assumes: register port writes come from the bus master frame handler
// Notes:   one clock; link pacing by a divider enable
`include "fbsm_defines.vh"

module fbsm_core (
    // clock and reset
    input  wire        mclk,
    input  wire        rst,
    // register port
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [15:0] reg_addr,
    input  wire [15:0] reg_wdata,
    output reg  [15:0] reg_rdata_q,
    output reg         reg_err_q,
    // state and channel status
    output reg  [3:0]  al_state_q,
    output reg         al_error_q,
    output reg  [3:0]  sm_enable_q,
    output reg  [2:0]  fmmu_enable_q,
    output reg         fw_reset_q,
    // received setpoint stream
    input  wire        pd_rx_valid,
    input  wire [15:0] pd_rx_data,
    output wire        pd_rx_ready,
    // setpoint to the application
    output reg         app_sp_valid_q,
    output reg  [15:0] app_sp_data_q,
    output reg         app_sp_default_q,
    input  wire        app_sp_ready,
    // actual values to the link
    input  wire [15:0] act_data,
    output reg         act_take_q,
    output reg         pd_tx_valid_q,
    output reg  [15:0] pd_tx_data_q,
    // mailbox frames
    input  wire        mbx_valid,
    input  wire [3:0]  mbx_proto,
    input  wire [3:0]  mbx_svc,
    output reg         mbx_accept_q,
    output reg         mbx_reject_q
);

    ////////////////////////////////////////////////////////////////////////////
    // state codes
    localparam [3:0] S_INIT   = `FBSM_ST_INIT;
    localparam [3:0] S_PREOP  = `FBSM_ST_PREOP;
    localparam [3:0] S_BOOT   = `FBSM_ST_BOOT;
    localparam [3:0] S_SAFEOP = `FBSM_ST_SAFEOP;
    localparam [3:0] S_OP     = `FBSM_ST_OP;

    // transition permitted by the scheme
    function allowed;
        input [3:0] cur;
        input [3:0] req;
        begin
            case (cur)
                S_INIT:   allowed = (req == S_PREOP) | (req == S_BOOT);
                S_PREOP:  allowed = (req == S_INIT) | (req == S_SAFEOP);
                S_SAFEOP: allowed = (req == S_INIT) | (req == S_PREOP) | (req == S_OP);
                S_OP:     allowed = (req == S_INIT) | (req == S_PREOP) | (req == S_SAFEOP);
                S_BOOT:   allowed = (req == S_INIT);
                default:  allowed = 1'b0;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // control word handling
    reg  [15:0] ctrl_q;
    reg  [3:0]  state_q;
    reg  [3:0]  state_d;
    reg         err_d;
    wire        ctrl_wr;
    wire [3:0]  req;
    wire        ack_rise;
    wire        mbx_on;
    wire        cyc_on;

    assign ctrl_wr  = reg_wr & (reg_addr == `FBSM_REG_CTRL);
    assign req      = reg_wdata[`FBSM_CTRL_REQ_HI:`FBSM_CTRL_REQ_LO];
    assign ack_rise = ctrl_wr & reg_wdata[`FBSM_CTRL_ACK_BIT] & ~ctrl_q[`FBSM_CTRL_ACK_BIT];

    always @* begin
        state_d = state_q;
        err_d   = al_error_q;
        if (ack_rise) begin
            err_d = 1'b0;
        end
        if (ctrl_wr && req != state_q) begin
            if (allowed(state_q, req)) begin
                state_d = req;
            end else begin
                err_d = 1'b1;
            end
        end
    end

    assign mbx_on = (state_q == S_PREOP) | (state_q == S_SAFEOP) |
                    (state_q == S_OP) | (state_q == S_BOOT);
    assign cyc_on = (state_q == S_SAFEOP) | (state_q == S_OP);

    always @(posedge mclk) begin
        if (rst) begin
            state_q    <= S_INIT;
            ctrl_q     <= `FBSM_CTRL_RESET;
            al_error_q <= 1'b0;
            fw_reset_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            al_error_q <= err_d;
            fw_reset_q <= (state_q == S_BOOT) & (state_d == S_INIT);
            if (ctrl_wr) begin
                ctrl_q <= reg_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read and channel enables
    always @(posedge mclk) begin
        if (rst) begin
            reg_rdata_q   <= 16'h0000;
            reg_err_q     <= 1'b0;
            al_state_q    <= S_INIT;
            sm_enable_q   <= 4'h0;
            fmmu_enable_q <= 3'h0;
        end else begin
            al_state_q <= state_d;
            reg_err_q  <= 1'b0;
            if (reg_rd) begin
                case (reg_addr)
                    `FBSM_REG_CTRL:   reg_rdata_q <= ctrl_q;
                    `FBSM_REG_STATUS: reg_rdata_q <= {11'h000, al_error_q, state_q};
                    default: begin
                        reg_rdata_q <= 16'h0000;
                        reg_err_q   <= 1'b1;
                    end
                endcase
            end
            sm_enable_q   <= {cyc_on, cyc_on, mbx_on, mbx_on};
            fmmu_enable_q <= {mbx_on, cyc_on, cyc_on};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link nibble pacing
    reg  [`FBSM_DIV_W-1:0] div_q;
    wire                   link_en;

    assign link_en = (div_q == `FBSM_LINK_DIV - 1);

    always @(posedge mclk) begin
        if (rst || link_en) begin
            div_q <= {`FBSM_DIV_W{1'b0}};
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // setpoint path through the fifo
    wire        f_out_valid;
    wire [15:0] f_out_data;
    wire        f_out_ready;

    assign f_out_ready = (state_q == S_OP) ? (~app_sp_valid_q | app_sp_ready) : 1'b1;

    fbsm_fifo #(
        .WIDTH (`FBSM_FIFO_WIDTH),
        .DEPTH (`FBSM_FIFO_DEPTH),
        .AW    (`FBSM_FIFO_AW)
    ) u_fifo (
        .mclk      (mclk),
        .rst       (rst),
        .in_valid  (pd_rx_valid & cyc_on),
        .in_data   (pd_rx_data),
        .in_ready  (pd_rx_ready),
        .out_valid (f_out_valid),
        .out_data  (f_out_data),
        .out_ready (f_out_ready)
    );

    always @(posedge mclk) begin
        if (rst) begin
            app_sp_valid_q   <= 1'b0;
            app_sp_data_q    <= `FBSM_DEF_SETPOINT;
            app_sp_default_q <= 1'b1;
        end else if (state_q == S_OP) begin
            app_sp_default_q <= 1'b0;
            if (f_out_valid && f_out_ready) begin
                app_sp_valid_q <= 1'b1;
                app_sp_data_q  <= f_out_data;
            end else if (app_sp_ready) begin
                app_sp_valid_q <= 1'b0;
            end
        end else begin
            app_sp_valid_q   <= 1'b0;
            app_sp_data_q    <= `FBSM_DEF_SETPOINT;
            app_sp_default_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // actual values out
    always @(posedge mclk) begin
        if (rst) begin
            act_take_q    <= 1'b0;
            pd_tx_valid_q <= 1'b0;
            pd_tx_data_q  <= 16'h0000;
        end else begin
            act_take_q    <= cyc_on & link_en;
            pd_tx_valid_q <= cyc_on & link_en;
            if (cyc_on && link_en) begin
                pd_tx_data_q <= act_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mailbox filter
    wire coe_ok;
    wire mbx_ok;

    assign coe_ok = (mbx_proto == `FBSM_PROTO_COE) &
                    ((mbx_svc == `FBSM_SDO_REQ) | (mbx_svc == `FBSM_SDO_RESP) |
                     (mbx_svc == `FBSM_SDO_CA));
    assign mbx_ok = (state_q == S_BOOT) ? (mbx_proto == `FBSM_PROTO_FOE) :
                    (mbx_on & coe_ok);

    always @(posedge mclk) begin
        if (rst) begin
            mbx_accept_q <= 1'b0;
            mbx_reject_q <= 1'b0;
        end else begin
            mbx_accept_q <= mbx_valid & mbx_ok;
            mbx_reject_q <= mbx_valid & ~mbx_ok;
        end
    end

endmodule

// ### tb/fbsm_core_properties.sv
// Purpose: port checks for fbsm_core
// Assumes: synchronous active high rst
// Notes:   attached by bind
module fbsm_core_props (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst,
    // register port
    input wire logic        reg_wr,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    // status
    input wire logic [3:0]  al_state_q,
    input wire logic        al_error_q,
    input wire logic [3:0]  sm_enable_q,
    input wire logic [2:0]  fmmu_enable_q,
    input wire logic        app_sp_default_q,
    input wire logic        act_take_q,
    // mailbox
    input wire logic        mbx_valid,
    input wire logic [3:0]  mbx_proto,
    input wire logic [3:0]  mbx_svc,
    input wire logic        mbx_accept_q,
    input wire logic        mbx_reject_q
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    wire       cw = reg_wr && reg_addr == 16'h0120;
    wire [3:0] rq = reg_wdata[3:0];
    reset_init_a: assert property (disable iff (1'b0) rst |=> al_state_q == 4'h1)
        else $error("state not init after reset");
    no_self_move_a: assert property (!cw |=> $stable(al_state_q))
        else $error("state moved without request");
    bad_code_a: assert property (cw && !(rq inside {1, 2, 3, 4, 8})
        |=> $stable(al_state_q) && al_error_q) else $error("unknown code accepted");
    init_skip_a: assert property (cw && al_state_q == 4'h1 && rq inside {4, 8}
        |=> al_state_q == 4'h1 && al_error_q) else $error("init skipped ahead");
    preop_move_a: assert property (cw && al_state_q == 4'h1 && rq == 4'h2
        |=> al_state_q == 4'h2) else $error("preop request not taken");
    preop_map_a: assert property (al_state_q == 4'h2 && $past(al_state_q) == 4'h2
        |-> sm_enable_q == 4'b0011 && fmmu_enable_q == 3'b100) else $error("preop map");
    init_reject_a: assert property (mbx_valid && al_state_q == 4'h1
        |=> mbx_reject_q && !mbx_accept_q) else $error("mailbox in init");
    boot_foe_a: assert property (mbx_valid && al_state_q == 4'h3
        |=> mbx_accept_q == ($past(mbx_proto) == 4'h4) && mbx_accept_q != mbx_reject_q)
        else $error("boot mailbox filter");
    sdo_accept_a: assert property (mbx_valid && al_state_q == 4'h2 && mbx_proto == 4'h3
        && mbx_svc inside {2, 3, 4} |=> mbx_accept_q) else $error("sdo refused");
    safe_default_a: assert property ((al_state_q == 4'h4)[*3] |-> app_sp_default_q)
        else $error("safeop not default");
    act_gap_a: assert property (act_take_q |=> (!act_take_q)[*3])
        else $error("actual pacing");
    cover property (al_state_q == 4'h8);
    cover property (mbx_valid && al_state_q == 4'h3);
    cover property (act_take_q && al_state_q == 4'h4);
endmodule

bind fbsm_core fbsm_core_props u_props (.mclk(mclk), .rst(rst), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .al_state_q(al_state_q),
    .al_error_q(al_error_q), .sm_enable_q(sm_enable_q), .fmmu_enable_q(fmmu_enable_q),
    .app_sp_default_q(app_sp_default_q), .act_take_q(act_take_q), .mbx_valid(mbx_valid),
    .mbx_proto(mbx_proto), .mbx_svc(mbx_svc), .mbx_accept_q(mbx_accept_q),
    .mbx_reject_q(mbx_reject_q));

// ### tb/fbsm_master_model.sv
// Purpose: bus master setpoint source
// Assumes: valid held until ready
// Notes:   data inverted while idle
module fbsm_master_model (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // control
    input  wire logic        go,
    // setpoint stream
    output logic             pd_rx_valid,
    output logic [15:0]      pd_rx_data,
    input  wire logic        pd_rx_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] idx_q;
    always @(posedge mclk) begin
        if (rst) begin
            pd_rx_valid <= 1'b0;
            idx_q       <= 16'h0000;
        end else if (pd_rx_valid && pd_rx_ready) begin
            idx_q       <= idx_q + 16'h0001;
            pd_rx_valid <= go && $urandom_range(3) != 0;
        end else if (!pd_rx_valid) begin
            pd_rx_valid <= go && $urandom_range(1) != 0;
            if (!go) idx_q <= 16'h0000;
        end
    end
    assign pd_rx_data = pd_rx_valid ? 16'h5a00 + idx_q : ~(16'h5a00 + idx_q);
endmodule

// ### tb/test_fieldbus_slave_state_machine.sv
// Purpose: self checking bench for fbsm_core
// Assumes: 100 MHz mclk, sync reset
// Notes:   random mailbox and stall patterns
`include "fbsm_defines.vh"
module test_fieldbus_slave_state_machine;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk, rst, reg_wr, reg_rd, reg_err_q, al_error_q, fw_reset_q, go, e;
    logic        pd_rx_valid, pd_rx_ready, app_sp_valid_q, app_sp_default_q, app_sp_ready;
    logic        act_take_q, pd_tx_valid_q, mbx_valid, mbx_accept_q, mbx_reject_q, bad;
    logic [2:0]  fmmu_enable_q;
    logic [3:0]  al_state_q, sm_enable_q, mbx_proto, mbx_svc;
    logic [15:0] reg_addr, reg_wdata, reg_rdata_q, pd_rx_data, app_sp_data_q;
    logic [15:0] act_data, pd_tx_data_q, d, n;
    logic [15:0] got[$];
    int          num_errors = 0, tests_run = 0, acc = 0, fwr = 0, k;

    fbsm_core DUT (.mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
        .reg_err_q(reg_err_q), .al_state_q(al_state_q), .al_error_q(al_error_q),
        .sm_enable_q(sm_enable_q), .fmmu_enable_q(fmmu_enable_q), .fw_reset_q(fw_reset_q),
        .pd_rx_valid(pd_rx_valid), .pd_rx_data(pd_rx_data), .pd_rx_ready(pd_rx_ready),
        .app_sp_valid_q(app_sp_valid_q), .app_sp_data_q(app_sp_data_q),
        .app_sp_default_q(app_sp_default_q), .app_sp_ready(app_sp_ready),
        .act_data(act_data), .act_take_q(act_take_q), .pd_tx_valid_q(pd_tx_valid_q),
        .pd_tx_data_q(pd_tx_data_q), .mbx_valid(mbx_valid), .mbx_proto(mbx_proto),
        .mbx_svc(mbx_svc), .mbx_accept_q(mbx_accept_q), .mbx_reject_q(mbx_reject_q));
    fbsm_master_model u_master (.mclk(mclk), .rst(rst), .go(go), .pd_rx_valid(pd_rx_valid),
        .pd_rx_data(pd_rx_data), .pd_rx_ready(pd_rx_ready));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("tests_run %0d num_errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(posedge mclk) #1 reg_wr = 1'b0;
        @(posedge mclk) #1;
    endtask
    task automatic rd(input logic [15:0] a);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge mclk) #1 reg_rd = 1'b0;
        d = reg_rdata_q;
        e = reg_err_q;
        @(posedge mclk) #1;
    endtask
    function automatic logic ok(input logic [3:0] st, input logic [3:0] p, input logic [3:0] s);
        if (st == `FBSM_ST_BOOT) return p == `FBSM_PROTO_FOE;
        if (st == `FBSM_ST_INIT) return 1'b0;
        return p == `FBSM_PROTO_COE && s inside {`FBSM_SDO_REQ, `FBSM_SDO_RESP, `FBSM_SDO_CA};
    endfunction
    task automatic mbr(input logic [3:0] st);
        logic x;
        repeat (8) begin
            mbx_proto = 4'($urandom_range(5, 2));
            mbx_svc = 4'($urandom_range(5, 1));
            x = ok(st, mbx_proto, mbx_svc);
            mbx_valid = 1'b1;
            @(posedge mclk) #1 mbx_valid = 1'b0;
            chk({14'h0, mbx_accept_q, mbx_reject_q}, {14'h0, x, !x});
            @(posedge mclk) #1;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge mclk) begin
        if (app_sp_valid_q === 1'b1 && app_sp_ready) got.push_back(app_sp_data_q);
        if (pd_rx_valid && pd_rx_ready === 1'b1 && al_state_q === `FBSM_ST_OP) acc++;
        if (fw_reset_q === 1'b1) fwr++;
    end
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        #300000;
        num_errors++;
        wrap_up();
    end
    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, go, app_sp_ready, mbx_valid, bad} = '0;
        {reg_addr, reg_wdata, act_data, n, mbx_proto, mbx_svc} = '0;
        void'($urandom(32'h16cf));
        repeat (4) @(posedge mclk);
        #1 rst = 1'b0;
        chk(16'(al_state_q), 16'(`FBSM_ST_INIT));
        rd(`FBSM_REG_CTRL);
        chk(d, `FBSM_CTRL_RESET);
        rd(16'h0200);
        chk({d[15:1], e}, 16'h0001);
        mbr(`FBSM_ST_INIT);
        wr(16'h0122, 16'h0002);
        chk(16'(al_state_q), 16'h0001);
        wr(`FBSM_REG_CTRL, 16'h0008);
        rd(`FBSM_REG_STATUS);
        chk(d, 16'h0011);
        wr(`FBSM_REG_CTRL, 16'h0011);
        chk({11'h0, al_error_q, al_state_q}, 16'h0001);
        wr(`FBSM_REG_CTRL, 16'h0002);
        chk({9'h0, fmmu_enable_q, sm_enable_q}, 16'h0043);
        mbr(`FBSM_ST_PREOP);
        wr(`FBSM_REG_CTRL, 16'h0004);
        go = 1'b1;
        repeat (8) @(posedge mclk) #1;
        repeat (40) begin
            @(posedge mclk) #1;
            if (pd_tx_valid_q === 1'b1) chk(pd_tx_data_q, act_data);
            act_data = 16'($urandom);
            n = n + 16'(act_take_q) + 16'(pd_tx_valid_q);
            bad = bad | app_sp_valid_q | !app_sp_default_q;
        end
        chk(n, 16'd20);
        chk(16'(bad), 16'h0000);
        chk(app_sp_data_q, `FBSM_DEF_SETPOINT);
        go = 1'b0;
        repeat (8) @(posedge mclk) #1;
        wr(`FBSM_REG_CTRL, 16'h0008);
        go = 1'b1;
        for (k = 0; k < 200 && pd_rx_ready !== 1'b0; k++) @(posedge mclk) #1;
        chk(16'(acc >= 16), 16'h0001);
        go = 1'b0;
        repeat (200) @(posedge mclk) #1 app_sp_ready = 1'($urandom);
        chk(16'(got.size()), 16'(acc));
        foreach (got[i]) chk(got[i], 16'h5a00 + 16'(i));
        wr(`FBSM_REG_CTRL, 16'h0003);
        chk({11'h0, al_error_q, al_state_q}, 16'h0018);
        wr(`FBSM_REG_CTRL, 16'h0004);
        chk({15'h0, app_sp_default_q}, 16'h0001);
        wr(`FBSM_REG_CTRL, 16'h0002);
        chk({9'h0, fmmu_enable_q, sm_enable_q}, 16'h0043);
        wr(`FBSM_REG_CTRL, 16'h0011);
        wr(`FBSM_REG_CTRL, 16'h0003);
        chk({11'h0, al_error_q, al_state_q}, 16'h0003);
        mbr(`FBSM_ST_BOOT);
        wr(`FBSM_REG_CTRL, 16'h0001);
        chk(16'(al_state_q), 16'h0001);
        chk(16'(fwr), 16'h0001);
        wrap_up();
    end
endmodule
